/* File: inc/remote_access_pkg.sv */
/*
 * Shared constants for the remote access command translator: opcodes,
 * control block layout, remote function codes, limits and status codes.
 * Assumes a host control block of consecutive 16-bit words in local memory.
 */
package remote_access_pkg;
    localparam int WORD_W = 16;
    localparam int ADDR_W = 16;
    localparam int CMD_WORDS = 10;
    localparam int ROUTE_DROPS = 7;

    // opcode word values
    localparam logic [15:0] OPC_READ_INPUTS = 16'h0067;
    localparam logic [15:0] OPC_READ_INREGS = 16'h006A;
    localparam logic [15:0] OPC_WRITE_ONE = 16'h006C;

    // remote function codes
    localparam logic [7:0] FC_READ_INPUTS = 8'h02;
    localparam logic [7:0] FC_READ_INREGS = 8'h04;
    localparam logic [7:0] FC_WRITE_ONE = 8'h06;

    // control block word positions; the last is the fetched source value
    localparam logic [3:0] IDX_OPCODE = 4'h0;
    localparam logic [15:0] IDX_STATUS = 16'h0001;
    localparam logic [3:0] IDX_COUNT = 4'h2;
    localparam logic [3:0] IDX_START = 4'h3;
    localparam logic [3:0] IDX_TARGET = 4'h4;
    localparam logic [3:0] IDX_EXT0 = 4'h5;
    localparam logic [3:0] IDX_EXT1 = 4'h6;
    localparam logic [3:0] IDX_EXT2 = 4'h7;
    localparam logic [3:0] IDX_EXT3 = 4'h8;
    localparam logic [3:0] IDX_VALUE = 4'h9;

    // transfer limits
    localparam logic [15:0] MAX_BITS = 16'h07D0;
    localparam logic [15:0] MAX_REGS = 16'h007D;
    localparam logic [7:0] MAX_DROPS = 8'h07;
    localparam logic [15:0] ONE_REG = 16'h0001;

    // status word codes
    localparam logic [15:0] ST_OK = 16'h0000;
    localparam logic [15:0] ST_BAD_OPCODE = 16'h0001;
    localparam logic [15:0] ST_BAD_COUNT = 16'h0002;
    localparam logic [15:0] ST_BAD_ROUTE = 16'h0003;
    localparam logic [15:0] ST_REMOTE_ERR = 16'h1000;

    // packer
    localparam logic [4:0] PACK_FULL = 5'h10;
    localparam logic [4:0] PACK_EMPTY = 5'h00;
    localparam logic [15:0] ZERO_WORD = 16'h0000;
endpackage : remote_access_pkg

/* File: hdl/bit_packer.sv */
/*
 * Packs a stream of single bits into 16-bit words, first bit in the MSB.
 * Assumes bit and flush strobes come from logic on the same clock.
 */
`timescale 1ns/1ps
module bit_packer (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // bit stream
    input wire logic clear,
    input wire logic bitValid,
    input wire logic bitIn,
    input wire logic flush,
    // packed words
    output logic wordValid,
    output logic [15:0] word
);
    logic [15:0] acc;
    logic [4:0] fill;

    wire [15:0] withBit = bitValid ? {acc[14:0], bitIn} : acc;
    wire [4:0] newFill = fill + {4'h0, bitValid};
    wire emit = (newFill == remote_access_pkg::PACK_FULL) ||
                (flush && newFill != remote_access_pkg::PACK_EMPTY);
    // partial word is left-aligned so trailing bits read as zero
    wire [4:0] padShift = remote_access_pkg::PACK_FULL - newFill;
    wire [15:0] aligned = withBit << padShift;

    always_ff @(posedge clk) begin
        if (rst || clear) begin
            acc <= remote_access_pkg::ZERO_WORD;
            fill <= remote_access_pkg::PACK_EMPTY;
            wordValid <= 1'b0;
            word <= remote_access_pkg::ZERO_WORD;
        end else begin
            wordValid <= emit;
            if (emit) begin
                word <= aligned;
                acc <= remote_access_pkg::ZERO_WORD;
                fill <= remote_access_pkg::PACK_EMPTY;
            end else begin
                acc <= withBit;
                fill <= newFill;
            end
        end
    end

    // helper for the flush check: first bit of the word being built
    logic firstBit;
    wire [15:0] tailMask = 16'hFFFF >> fill;

    always_ff @(posedge clk) begin
        if (rst || clear) begin
            firstBit <= 1'b0;
        end else if (bitValid && fill == remote_access_pkg::PACK_EMPTY) begin
            firstBit <= bitIn;
        end
    end

    AST_PACK_FIRST_MSB: assert property (@(posedge clk) disable iff (rst || clear)
        flush && !bitValid && fill != remote_access_pkg::PACK_EMPTY
        |=> wordValid && word[15] == $past(firstBit) && (word & $past(tailMask)) == 16'h0000)
        else $error("flushed word not msb-first with zero fill");
endmodule : bit_packer

/* File: hdl/remote_access_command_translator.sv */
/*
 * Remote access command translator: fetches a host control block, issues one
 * remote read or write request, stores the answer into local holding words
 * and writes the outcome back into the control block status word.
 * Assumes host memory, host strobes and the remote engine share clk; memory
 * read data is valid on the cycle after memRead is seen high.
 */
`timescale 1ns/1ps
// Functional notes
// - opcode 103 issues remote function 2, reading discrete input bits.
// - read results are stored from the local data base address upward.
// - input-bit read takes its remote start bit from control word three.
// - input-bit read takes its bit count from control word two.
// - network target: slot from word four high byte, unit from low byte.
// - bits pack first-bit-in-MSB, downward then onward, unused trailing bits zero.
// - opcode 106 issues remote function 4, reading input registers.
// - input-register read takes its remote start from control word three.
// - input-register read takes its register count from control word two.
// - remote registers land one-to-one, ascending, from the data base.
// - opcode 108 issues remote function 6, writing one holding register.
// - single write takes its value from the local word at data base.
// - single write takes its remote register from control word three.
// - single write ignores control word two; count is always one.
// - serial target: drop count and route bytes from words five on, max seven.
module remote_access_command_translator (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // host command
    input wire logic cmdStart,
    input wire logic [15:0] ctrlBase,
    input wire logic [15:0] dataBase,
    input wire logic targetSerial,
    output logic busy,
    output logic cmdDone,
    output logic [15:0] cmdStatus,
    // host memory
    output logic memRead,
    output logic memWrite,
    output logic [15:0] memAddr,
    output logic [15:0] memWriteData,
    input wire logic [15:0] memReadData,
    // remote request
    output logic reqValid,
    input wire logic reqReady,
    output logic [7:0] reqFunction,
    output logic [7:0] reqSlot,
    output logic [7:0] reqUnit,
    output logic [31:0] reqIp,
    output logic reqSerial,
    output logic [7:0] reqDropCount,
    output logic [55:0] reqRoute,
    output logic [15:0] reqStart,
    output logic [15:0] reqCount,
    output logic [15:0] reqValue,
    // remote response
    input wire logic rspValid,
    input wire logic [15:0] rspData,
    input wire logic rspDone,
    input wire logic rspError,
    input wire logic [7:0] rspException
);
    typedef enum logic [2:0] {S_IDLE, S_FETCH, S_CHECK, S_ISSUE, S_WAIT, S_DRAIN, S_STATUS} state_e;

    state_e state;
    state_e next_state;
    logic [15:0] cmdWord [remote_access_pkg::CMD_WORDS];
    logic [15:0] baseCtrl;
    logic [15:0] baseData;
    logic serialTgt;
    logic [3:0] issueIdx;
    logic [3:0] rdTag;
    logic rdPend;
    logic rdIssued;
    logic [3:0] rdIssuedTag;
    logic [15:0] itemCount;
    logic [15:0] wordIdx;
    logic [15:0] outcome;
    logic packValid;
    logic [15:0] packWord;

    // command decode
    wire [15:0] opcode = cmdWord[remote_access_pkg::IDX_OPCODE];
    wire isBits = opcode == remote_access_pkg::OPC_READ_INPUTS;
    wire isRegs = opcode == remote_access_pkg::OPC_READ_INREGS;
    wire isWrite = opcode == remote_access_pkg::OPC_WRITE_ONE;
    wire [15:0] wantCount = cmdWord[remote_access_pkg::IDX_COUNT];
    wire [7:0] dropCount = cmdWord[remote_access_pkg::IDX_EXT0][15:8];
    wire badOpcode = !(isBits || isRegs || isWrite);
    wire badCount = (isBits && (wantCount == remote_access_pkg::ZERO_WORD || wantCount > remote_access_pkg::MAX_BITS)) ||
                    (isRegs && (wantCount == remote_access_pkg::ZERO_WORD || wantCount > remote_access_pkg::MAX_REGS));
    wire badRoute = serialTgt && (dropCount == 8'h00 || dropCount > remote_access_pkg::MAX_DROPS);
    wire [15:0] checkCode = badOpcode ? remote_access_pkg::ST_BAD_OPCODE :
                            badCount ? remote_access_pkg::ST_BAD_COUNT :
                            badRoute ? remote_access_pkg::ST_BAD_ROUTE : remote_access_pkg::ST_OK;

    // response acceptance; items beyond the requested count are dropped
    wire accept = (state == S_WAIT) && rspValid && (itemCount < reqCount);
    wire regStore = accept && isRegs;
    wire bitFeed = accept && isBits;
    wire bitFlush = (state == S_WAIT) && rspDone && isBits;
    wire [15:0] rspCode = rspError ? (remote_access_pkg::ST_REMOTE_ERR | {8'h00, rspException}) :
                          remote_access_pkg::ST_OK;

    // memory port next values
    wire fetchIssue = (state == S_FETCH) && (issueIdx < 4'(remote_access_pkg::CMD_WORDS));
    wire [15:0] fetchAddr = (issueIdx == remote_access_pkg::IDX_VALUE) ? baseData : baseCtrl + {12'h000, issueIdx};
    wire statusWrite = state == S_STATUS;
    wire next_memWrite = regStore || packValid || statusWrite;
    wire [15:0] next_memAddr = statusWrite ? baseCtrl + remote_access_pkg::IDX_STATUS :
                               regStore ? baseData + itemCount :
                               packValid ? baseData + wordIdx : fetchAddr;
    wire [15:0] next_memWriteData = statusWrite ? outcome : regStore ? rspData : packWord;
    wire fetchLast = rdPend && (rdTag == remote_access_pkg::IDX_VALUE);

    always_comb begin
        next_state = state;
        case (state)
            S_IDLE: if (cmdStart) next_state = S_FETCH;
            S_FETCH: if (fetchLast) next_state = S_CHECK;
            S_CHECK: next_state = (checkCode == remote_access_pkg::ST_OK) ? S_ISSUE : S_STATUS;
            S_ISSUE: if (reqReady) next_state = S_WAIT;
            S_WAIT: if (rspDone) next_state = S_DRAIN;
            S_DRAIN: next_state = S_STATUS;
            S_STATUS: next_state = S_IDLE;
            default: next_state = S_IDLE;
        endcase
    end

    bit_packer packer (
        .clk(clk),
        .rst(rst),
        .clear(state == S_CHECK),
        .bitValid(bitFeed),
        .bitIn(rspData[0]),
        .flush(bitFlush),
        .wordValid(packValid),
        .word(packWord)
    );

    always_ff @(posedge clk) begin
        if (rst) begin
            state <= S_IDLE;
            busy <= 1'b0;
            cmdDone <= 1'b0;
            cmdStatus <= remote_access_pkg::ST_OK;
            memRead <= 1'b0;
            memWrite <= 1'b0;
            memAddr <= remote_access_pkg::ZERO_WORD;
            memWriteData <= remote_access_pkg::ZERO_WORD;
        end else begin
            state <= next_state;
            busy <= next_state != S_IDLE;
            cmdDone <= statusWrite;
            if (statusWrite) cmdStatus <= outcome;
            memRead <= fetchIssue;
            memWrite <= next_memWrite;
            memAddr <= next_memAddr;
            memWriteData <= next_memWriteData;
        end
    end

    // fetch sequencing and command capture
    always_ff @(posedge clk) begin
        if (rst) begin
            issueIdx <= 4'h0;
            rdPend <= 1'b0;
            rdTag <= 4'h0;
            rdIssued <= 1'b0;
            rdIssuedTag <= 4'h0;
            baseCtrl <= remote_access_pkg::ZERO_WORD;
            baseData <= remote_access_pkg::ZERO_WORD;
            serialTgt <= 1'b0;
            for (int i = 0; i < remote_access_pkg::CMD_WORDS; i++) cmdWord[i] <= remote_access_pkg::ZERO_WORD;
        end else begin
            if (state == S_IDLE && cmdStart) begin
                baseCtrl <= ctrlBase;
                baseData <= dataBase;
                serialTgt <= targetSerial;
                issueIdx <= 4'h0;
            end else if (fetchIssue) begin
                issueIdx <= issueIdx + 4'h1;
            end
            rdIssued <= fetchIssue;
            rdIssuedTag <= issueIdx;
            // memory answers the cycle after the strobe, so capture trails the issue by two
            rdPend <= rdIssued;
            rdTag <= rdIssuedTag;
            if (rdPend) cmdWord[rdTag] <= memReadData;
        end
    end

    // request build and response bookkeeping
    always_ff @(posedge clk) begin
        if (rst) begin
            reqValid <= 1'b0;
            reqFunction <= 8'h00;
            reqSlot <= 8'h00;
            reqUnit <= 8'h00;
            reqIp <= 32'h00000000;
            reqSerial <= 1'b0;
            reqDropCount <= 8'h00;
            reqRoute <= 56'h00000000000000;
            reqStart <= remote_access_pkg::ZERO_WORD;
            reqCount <= remote_access_pkg::ZERO_WORD;
            reqValue <= remote_access_pkg::ZERO_WORD;
            itemCount <= remote_access_pkg::ZERO_WORD;
            wordIdx <= remote_access_pkg::ZERO_WORD;
            outcome <= remote_access_pkg::ST_OK;
        end else begin
            if (state == S_CHECK) begin
                outcome <= checkCode;
                itemCount <= remote_access_pkg::ZERO_WORD;
                wordIdx <= remote_access_pkg::ZERO_WORD;
                reqValid <= checkCode == remote_access_pkg::ST_OK;
                reqFunction <= isBits ? remote_access_pkg::FC_READ_INPUTS :
                               isRegs ? remote_access_pkg::FC_READ_INREGS :
                               remote_access_pkg::FC_WRITE_ONE;
                reqStart <= cmdWord[remote_access_pkg::IDX_START];
                reqCount <= isWrite ? remote_access_pkg::ONE_REG : wantCount;
                reqValue <= isWrite ? cmdWord[remote_access_pkg::IDX_VALUE] : remote_access_pkg::ZERO_WORD;
                reqSlot <= cmdWord[remote_access_pkg::IDX_TARGET][15:8];
                reqUnit <= serialTgt ? 8'h00 : cmdWord[remote_access_pkg::IDX_TARGET][7:0];
                reqSerial <= serialTgt;
                reqIp <= serialTgt ? 32'h00000000 :
                         {cmdWord[remote_access_pkg::IDX_EXT0][7:0], cmdWord[remote_access_pkg::IDX_EXT1][7:0],
                          cmdWord[remote_access_pkg::IDX_EXT2][7:0], cmdWord[remote_access_pkg::IDX_EXT3][7:0]};
                reqDropCount <= serialTgt ? dropCount : 8'h00;
                // first drop in the low byte of word five, then two per word, high first
                reqRoute <= serialTgt ? {cmdWord[remote_access_pkg::IDX_EXT0][7:0], cmdWord[remote_access_pkg::IDX_EXT1],
                                         cmdWord[remote_access_pkg::IDX_EXT2], cmdWord[remote_access_pkg::IDX_EXT3]} :
                            56'h00000000000000;
            end else if (state == S_ISSUE && reqReady) begin
                reqValid <= 1'b0;
            end
            if (accept) itemCount <= itemCount + 16'h0001;
            if (packValid) wordIdx <= wordIdx + 16'h0001;
            // a late remote error still lands: the check code is already clear here
            if (state == S_WAIT && rspDone) outcome <= rspCode;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence reqRaised;
        $rose(reqValid);
    endsequence

    AST_FUNC_INPUTS: assert property (reqRaised and isBits |-> reqFunction == 8'h02)
        else $error("input-bit read did not request function 2");
    AST_FUNC_INREGS: assert property (reqRaised and isRegs |-> reqFunction == 8'h04)
        else $error("input-register read did not request function 4");
    AST_FUNC_WRITE: assert property (reqRaised and isWrite |-> reqFunction == 8'h06 && reqCount == 16'h0001 &&
        reqValue == cmdWord[9])
        else $error("single write request malformed");
    AST_START_COUNT: assert property (reqRaised |-> reqStart == cmdWord[3] && (isWrite || reqCount == cmdWord[2]))
        else $error("start or count not taken from control block");
    AST_NET_TARGET: assert property (reqRaised and !reqSerial |-> reqSlot == cmdWord[4][15:8] &&
        reqUnit == cmdWord[4][7:0] && reqIp[31:24] == cmdWord[5][7:0] && reqIp[7:0] == cmdWord[8][7:0])
        else $error("network target fields wrong");
    AST_NET_IP_MID: assert property (reqRaised and !reqSerial |-> reqIp[23:16] == cmdWord[6][7:0] &&
        reqIp[15:8] == cmdWord[7][7:0])
        else $error("middle address octets wrong");
    AST_SERIAL_ROUTE: assert property (reqRaised and reqSerial |-> reqDropCount == cmdWord[5][15:8] &&
        reqRoute[55:48] == cmdWord[5][7:0] && reqDropCount <= 8'h07)
        else $error("serial route fields wrong");
    AST_SERIAL_TAIL: assert property (reqRaised and reqSerial |-> reqRoute[7:0] == cmdWord[8][7:0] &&
        reqUnit == 8'h00 && reqIp == 32'h00000000)
        else $error("serial route tail or unused fields wrong");
    AST_REQ_HOLD: assert property (reqValid && !reqReady |=> reqValid && $stable(reqStart) && $stable(reqCount))
        else $error("request dropped or changed before it was taken");
    AST_VALUE_FETCH: assert property (fetchIssue && issueIdx == remote_access_pkg::IDX_VALUE |=>
        memRead && memAddr == $past(baseData))
        else $error("write value not fetched from the data base");
    AST_REG_STORE: assert property (regStore |=> memWrite && memAddr == $past(baseData) + $past(itemCount) &&
        memWriteData == $past(rspData))
        else $error("input register not stored at its ascending slot");
    AST_PACK_STORE: assert property (packValid |=> memWrite && memAddr == $past(baseData) + $past(wordIdx) &&
        memWriteData == $past(packWord))
        else $error("packed word not stored at its ascending slot");
    AST_BAD_NO_REQ: assert property (state == S_CHECK && checkCode != remote_access_pkg::ST_OK |=>
        !reqValid && state == S_STATUS)
        else $error("refused command still raised a request");

    // the answer ends, then one drain cycle before the status slot
    sequence answerEnds;
        (state == S_WAIT && rspDone) ##1 (state == S_DRAIN);
    endsequence

    AST_STATUS_WRITE: assert property (answerEnds ##1 1'b1 |=>
        memWrite && memAddr == baseCtrl + 16'h0001 && cmdDone)
        else $error("outcome not written to status word");
    AST_IDLE_AT_DONE: assert property (cmdDone |-> !busy)
        else $error("busy still high with the done pulse");
    AST_NO_EXTRA: assert property (state == S_WAIT && rspValid && itemCount >= reqCount |=> !memWrite || packValid)
        else $error("item beyond requested count stored");
endmodule : remote_access_command_translator

/* File: verif/host_memory_model.sv */
/*
 * Host memory holding control blocks and data words for the translator bench.
 * Assumes the requester raises memRead or memWrite for one clock per access.
 */
`timescale 1ns/1ps
module host_memory_model (
    // clock
    input wire logic clk,
    // access
    input wire logic memRead,
    input wire logic memWrite,
    input wire logic [15:0] memAddr,
    input wire logic [15:0] memWriteData,
    output logic [15:0] memReadData
);
    logic [15:0] mem [0:255];

    initial begin
        memReadData = 16'h0000;
    end

    // data only valid the cycle after a read; otherwise it toggles so a late sample shows
    always_ff @(posedge clk) begin
        if (memRead) begin
            memReadData <= mem[memAddr[7:0]];
        end else begin
            memReadData <= ~memReadData;
        end
        if (memWrite) begin
            mem[memAddr[7:0]] <= memWriteData;
        end
    end
endmodule : host_memory_model

/* File: verif/test_remote_access_command_translator.sv */
/*
 * Self-checking bench: runs command blocks through the translator and plays
 * the remote engine; host memory comes from host_memory_model.
 */
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin totalChecks++; if ((got) !== (exp)) begin errorCnt++; \
    $display("MISMATCH %s expected %h seen %h", nm, exp, got); end end
module test_remote_access_command_translator;
    localparam logic [15:0] CB = 16'h0010;
    localparam logic [15:0] DB = 16'h0040;
    logic clk, rst, cmdStart, targetSerial, busy, cmdDone;
    logic [15:0] ctrlBase, dataBase, cmdStatus, memAddr, memWriteData, memReadData;
    logic memRead, memWrite, reqValid, reqReady, reqSerial, rspValid, rspDone, rspError;
    logic [7:0] reqFunction, reqSlot, reqUnit, reqDropCount, rspException;
    logic [31:0] reqIp;
    logic [55:0] reqRoute;
    logic [15:0] reqStart, reqCount, reqValue, rspData;
    logic [15:0] rspQ [$];
    int errorCnt = 0;
    int totalChecks = 0;

    remote_access_command_translator u_dut (
        .clk(clk), .rst(rst), .cmdStart(cmdStart), .ctrlBase(ctrlBase), .dataBase(dataBase),
        .targetSerial(targetSerial), .busy(busy), .cmdDone(cmdDone), .cmdStatus(cmdStatus),
        .memRead(memRead), .memWrite(memWrite), .memAddr(memAddr), .memWriteData(memWriteData),
        .memReadData(memReadData), .reqValid(reqValid), .reqReady(reqReady), .reqFunction(reqFunction),
        .reqSlot(reqSlot), .reqUnit(reqUnit), .reqIp(reqIp), .reqSerial(reqSerial),
        .reqDropCount(reqDropCount), .reqRoute(reqRoute), .reqStart(reqStart), .reqCount(reqCount),
        .reqValue(reqValue), .rspValid(rspValid), .rspData(rspData), .rspDone(rspDone),
        .rspError(rspError), .rspException(rspException)
    );

    host_memory_model u_mem (
        .clk(clk), .memRead(memRead), .memWrite(memWrite), .memAddr(memAddr),
        .memWriteData(memWriteData), .memReadData(memReadData)
    );

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic completeRun();
        $display("checks %0d mismatches %0d", totalChecks, errorCnt);
        if (errorCnt == 0 && totalChecks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : completeRun

    task automatic load(input logic [15:0] w [9]);
        for (int i = 0; i < 9; i++) u_mem.mem[CB[7:0] + i] = w[i];
    endtask : load

    // one command; the remote side stalls reqReady for one cycle more than the given stall
    task automatic runCmd(input logic [7:0] fn, input logic [15:0] st, input logic [15:0] cnt,
        input logic [15:0] val, input logic [7:0] slot, input logic [7:0] unit, input logic [31:0] ip,
        input logic [7:0] drops, input logic [55:0] route, input logic ser, input int stall,
        input logic err, input logic [7:0] exc, input logic [15:0] status);
        int n;
        n = 0;
        @(posedge clk);
        cmdStart <= 1'b1;
        targetSerial <= ser;
        @(posedge clk);
        cmdStart <= 1'b0;
        #1;
        `CHK("busy", 1'b1, busy)
        while (reqValid !== 1'b1 && cmdDone !== 1'b1 && n < 100) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (cmdDone !== 1'b1) begin
            `CHK("reqFunction", fn, reqFunction)
            `CHK("reqStart", st, reqStart)
            `CHK("reqCount", cnt, reqCount)
            `CHK("reqValue", val, reqValue)
            `CHK("reqSlot", slot, reqSlot)
            `CHK("reqUnit", unit, reqUnit)
            `CHK("reqIp", ip, reqIp)
            `CHK("reqSerial", ser, reqSerial)
            `CHK("reqDropCount", drops, reqDropCount)
            `CHK("reqRoute", route, reqRoute)
            repeat (stall + 1) @(posedge clk);
            reqReady <= 1'b1;
            @(posedge clk);
            reqReady <= 1'b0;
            foreach (rspQ[i]) begin
                @(posedge clk);
                rspValid <= 1'b1;
                rspData <= rspQ[i];
            end
            @(posedge clk);
            rspValid <= 1'b0;
            rspData <= ~rspData;
            rspDone <= 1'b1;
            rspError <= err;
            rspException <= exc;
            @(posedge clk);
            rspDone <= 1'b0;
            rspError <= 1'b0;
            #1;
            n = 0;
            while (cmdDone !== 1'b1 && n < 100) begin
                @(posedge clk);
                #1;
                n++;
            end
        end
        `CHK("cmdDone", 1'b1, cmdDone)
        `CHK("cmdStatus", status, cmdStatus)
        @(posedge clk);
        #1;
        `CHK("statusWord", status, u_mem.mem[CB[7:0] + 1])
        `CHK("busyIdle", 1'b0, busy)
        rspQ.delete();
    endtask : runCmd

    initial begin
        logic [31:0] bitsW;
        rst = 1'b1;
        cmdStart = 1'b0;
        ctrlBase = CB;
        dataBase = DB;
        targetSerial = 1'b0;
        reqReady = 1'b0;
        rspValid = 1'b0;
        rspData = 16'h0000;
        rspDone = 1'b0;
        rspError = 1'b0;
        rspException = 8'h00;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        // 25 input bits; upper rspData bits are junk that must be ignored
        load('{remote_access_pkg::OPC_READ_INPUTS, 16'h0000, 16'h0019, 16'h00DF, 16'h030C,
            16'h000A, 16'h0064, 16'h0002, 16'h007B});
        u_mem.mem[8'h41] = 16'hFFFF;
        bitsW = 32'h12345600;
        for (int i = 0; i < 25; i++) rspQ.push_back({15'h2AAA, bitsW[31 - i]});
        runCmd(8'h02, 16'h00DF, 16'h0019, 16'h0000, 8'h03, 8'h0C, 32'h0A64027B, 8'h00, 56'h0, 1'b0, 0,
            1'b0, 8'h00, remote_access_pkg::ST_OK);
        `CHK("bitWord0", 16'h1234, u_mem.mem[8'h40])
        `CHK("bitWord1", 16'h5600, u_mem.mem[8'h41])
        $display("test read_inputs done");
        load('{remote_access_pkg::OPC_READ_INREGS, 16'h0000, 16'h0004, 16'h0005, 16'h0401,
            16'h00CE, 16'h00DF, 16'h0033, 16'h00A9});
        for (int i = 0; i < 4; i++) rspQ.push_back(16'hA001 + 16'(i));
        runCmd(8'h04, 16'h0005, 16'h0004, 16'h0000, 8'h04, 8'h01, 32'hCEDF33A9, 8'h00, 56'h0, 1'b0, 3,
            1'b0, 8'h00, remote_access_pkg::ST_OK);
        for (int i = 0; i < 4; i++) `CHK("regWord", 16'hA001 + 16'(i), u_mem.mem[8'h40 + i])
        $display("test read_inregs done");
        // count word is junk: a single write must not look at it
        load('{remote_access_pkg::OPC_WRITE_ONE, 16'h0000, 16'hFFFF, 16'h0001, 16'h0300,
            16'h020E, 16'h1700, 16'h0000, 16'h0000});
        u_mem.mem[8'h40] = 16'hBEEF;
        runCmd(8'h06, 16'h0001, remote_access_pkg::ONE_REG, 16'hBEEF, 8'h03, 8'h00, 32'h0, 8'h02,
            56'h0E170000000000, 1'b1, 1, 1'b0, 8'h00, remote_access_pkg::ST_OK);
        $display("test write_one done");
        load('{remote_access_pkg::OPC_READ_INREGS, 16'h0000, 16'h0001, 16'h0005, 16'h0401,
            16'h00CE, 16'h00DF, 16'h0033, 16'h00A9});
        // second item is beyond the count of one and must not be stored
        rspQ.push_back(16'h1111);
        rspQ.push_back(16'h2222);
        runCmd(8'h04, 16'h0005, 16'h0001, 16'h0000, 8'h04, 8'h01, 32'hCEDF33A9, 8'h00, 56'h0, 1'b0, 0,
            1'b1, 8'h02, remote_access_pkg::ST_REMOTE_ERR | 16'h0002);
        `CHK("extraItem", 16'hA002, u_mem.mem[8'h41])
        $display("test remote_error done");
        load('{16'h0065, 16'h0000, 16'h0004, 16'h0005, 16'h0401, 16'h0, 16'h0, 16'h0, 16'h0});
        runCmd(8'h00, 16'h0, 16'h0, 16'h0, 8'h0, 8'h0, 32'h0, 8'h0, 56'h0, 1'b0, 0, 1'b0, 8'h00,
            remote_access_pkg::ST_BAD_OPCODE);
        $display("test bad_opcode done");
        load('{remote_access_pkg::OPC_READ_INPUTS, 16'h0000, 16'h07D1, 16'h0005, 16'h0401, 16'h0, 16'h0, 16'h0,
            16'h0});
        runCmd(8'h00, 16'h0, 16'h0, 16'h0, 8'h0, 8'h0, 32'h0, 8'h0, 56'h0, 1'b0, 0, 1'b0, 8'h00,
            remote_access_pkg::ST_BAD_COUNT);
        $display("test bad_count done");
        load('{remote_access_pkg::OPC_WRITE_ONE, 16'h0000, 16'h0001, 16'h0001, 16'h0300, 16'h0801, 16'h0, 16'h0,
            16'h0});
        runCmd(8'h00, 16'h0, 16'h0, 16'h0, 8'h0, 8'h0, 32'h0, 8'h0, 56'h0, 1'b1, 0, 1'b0, 8'h00,
            remote_access_pkg::ST_BAD_ROUTE);
        $display("test bad_route done");
        completeRun();
    end

    // seven short commands need well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        errorCnt++;
        completeRun();
    end
endmodule : test_remote_access_command_translator
